// [hdl/ddic_map.svh]
/*
  Holds the named constants of the drive interface control block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef DDIC_MAP_SVH
`define DDIC_MAP_SVH

`define DDIC_SYNC_RST      1'b1
`define DDIC_TRACK_W       8
`define DDIC_TRACK_ZERO    8'h00
`define DDIC_TRACK_LAST    8'hff
`define DDIC_HOLD_CYC      4'h8
`define DDIC_TRIM_ON_US    425
`define DDIC_TRIM_OFF_US   950
`define DDIC_CLK_MHZ       50
`define DDIC_TRIM_ON_CYC   (`DDIC_TRIM_ON_US * `DDIC_CLK_MHZ)
`define DDIC_TRIM_OFF_CYC  (`DDIC_TRIM_OFF_US * `DDIC_CLK_MHZ)
`define DDIC_TRIM_W        16

`endif

// [hdl/ddic_pkg.sv]
/*
  Holds the types shared by the drive interface control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ddic_pkg;

  // Strap settings, captured once after reset.
  typedef struct packed {
    logic motor_and_strap;
    logic motor_or_strap;
    logic direction_head_strap;
    logic separate_head_strap;
    logic door_latch_bypass_strap;
    logic protect_invert_strap;
    logic protect_normal_strap_a;
    logic protect_normal_strap_b;
    logic always_select_strap;
    logic [3:0] address_strap;
  } ddic_straps_t;

  // Active-low host inputs, taken together.
  typedef struct packed {
    logic [3:0] select_n;
    logic       spindle_on_n;
    logic       seek_direction_n;
    logic       step_n;
    logic       write_bitstream_n;
    logic       write_gate_n;
    logic       head_choice_n;
  } ddic_host_in_t;

  // Positioner states.
  typedef enum logic [1:0] {
    DDIC_POS_IDLE = 2'b00,
    DDIC_POS_MOVE = 2'b01,
    DDIC_POS_HOLD = 2'b10
  } ddic_pos_state_t;

endpackage

// [hdl/ddic_sync.sv]
/*
  Two-stage synchroniser for a bus of host lines.
  Assumes inputs idle high (inactive) at reset.
*/
`timescale 1ns/1ns
module ddic_sync #(
  parameter int W = 10
) (
  input  wire logic         sys_clk, // System clock.
  input  wire logic         srst,    // Synchronous reset, active high.
  input  wire logic [W-1:0] d_in,    // Asynchronous lines.
  output logic      [W-1:0] d_out    // Synchronised lines.
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_reg <= '1;
      d_out    <= '1;
    end else begin
      meta_reg <= d_in;
      d_out    <= meta_reg;
    end
  end

endmodule

// [hdl/ddic_trim.sv]
/*
  Trim-erase window timer around the write gate.
  Assumes a synchronised, active-high write request.
*/
`timescale 1ns/1ns
`include "ddic_map.svh"
module ddic_trim (
  input  wire logic sys_clk,  // System clock.
  input  wire logic srst,     // Synchronous reset, active high.
  input  wire logic wr_act,   // Write gate asserted.
  output logic      busy      // Write gate or trim erase active.
);

  logic [`DDIC_TRIM_W-1:0] cnt_reg;
  logic                    prev_reg;

  // Holds busy while writing and for the trailing trim period.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_reg  <= '0;
      prev_reg <= 1'b0;
      busy     <= 1'b0;
    end else begin
      prev_reg <= wr_act;
      if (wr_act) begin
        busy    <= 1'b1;
        cnt_reg <= `DDIC_TRIM_W'(`DDIC_TRIM_OFF_CYC);
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - `DDIC_TRIM_W'(1);
        busy    <= 1'b1;
      end else begin
        busy <= 1'b0;
      end
    end
  end

endmodule

// [hdl/ddic_top.sv]
/*
  Drive interface control: spindle, stepping, heads, write gating,
  track zero, protect, door-closed and drive-status outputs.
  Assumes straps are static, host lines are active low and asynchronous,
  and the mechanism reports door, notch, sector and speed as levels.
*/
// Decided for this implementation: the placing of the registers.
//
// Contract
// [RULE_01] No motor strap: motor follows motor-on.
// [RULE_02] AND strap: motor-on and selected.
// [RULE_03] OR strap: motor-on or selected.
// [RULE_04] Direction low steps inward, higher track.
// [RULE_05] Direction high steps outward, lower track.
// [RULE_06] One track per step pulse.
// [RULE_07] Direction strap: direction picks the head.
// [RULE_08] Direction head choice ignored while stepping.
// [RULE_09] Write enabled unless protected or stepping.
// [RULE_10] Gate high: read data drives output.
// [RULE_11] Track zero needs position zero and hold.
// [RULE_12] Host counts tracks from track zero.
// [RULE_13] Normal polarity: covered notch protects.
// [RULE_14] Inverted polarity: uncovered notch protects.
// [RULE_15] Head-select input low upper, high lower.
// [RULE_16] Bypass strap: door output follows door.
// [RULE_17] No bypass: door-open latched until deselect.
// [RULE_18] Bypass: status needs select, door, ready.
// [RULE_19] No bypass: status needs unopened door.
// [RULE_20] Ready needs sector seen and speed.
// [RULE_21] Selected by matching line or always-strap.
// [RULE_22] Steps and reading blocked during write/trim.
// [RULE_23] Synchronise inputs; count each falling step.
// [RULE_24] Straps sampled at reset; conflicts unsupported.
`timescale 1ns/1ns
`include "ddic_map.svh"
module ddic_top (
  input  wire logic                  sys_clk,        // System clock, 50 MHz.
  input  wire logic                  srst,           // Synchronous reset, active high.
  input  wire ddic_pkg::ddic_straps_t straps_in,     // Strap settings.
  input  wire ddic_pkg::ddic_host_in_t host_in,      // Active-low host lines.
  input  wire logic                  door_closed,    // Door closed sensor.
  input  wire logic                  notch_covered,  // Protect notch covered.
  input  wire logic                  sector_hole,    // Sector or index hole seen.
  input  wire logic                  at_speed,       // Spindle at speed.
  input  wire logic                  dual_head,      // Drive has two heads.
  input  wire logic                  media_read_n,   // Raw read data from head.
  output logic                       spindle_run,    // Spindle motor enable.
  output logic                       step_pulse,     // One-cycle step to stepper.
  output logic                       step_inward,    // Stepper direction.
  output logic                       upper_head,     // Upper head picked.
  output logic                       write_enable,   // Write circuits on.
  output logic                       write_flux_n,   // Write stream to head.
  output logic                       read_bitstream_n, // Read data to host.
  output logic                       home_track_n,   // Track-zero output.
  output logic                       protect_status_n, // Write-protect output.
  output logic                       door_closed_n,  // Door-closed output.
  output logic                       drive_status_n, // Drive-status output.
  output logic [`DDIC_TRACK_W-1:0]   track_pos       // Current track.
);

  ddic_pkg::ddic_straps_t  straps_reg;
  ddic_pkg::ddic_host_in_t hs;
  ddic_pkg::ddic_pos_state_t pos_reg;
  logic       step_prev_reg;
  logic [3:0] hold_reg;
  logic       trim_busy;
  logic       selected;
  logic       step_fall;
  logic       stepping;
  logic       protected_w;
  logic       door_open_seen_reg;
  logic       sector_seen_reg;
  logic       ready_w;
  logic       dir_head_reg;
  logic       first_reg;

  // Decodes selection from the address straps and select lines.
  function automatic logic sel_decode(input logic [3:0] addr, input logic always_sel,
                                      input logic [3:0] lines_n);
    sel_decode = always_sel | (|(addr & ~lines_n));
  endfunction

  // Host lines are synchronised before use. [RULE_23]
  ddic_sync #(.W($bits(ddic_pkg::ddic_host_in_t))) u_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d_in    (host_in),
    .d_out   (hs)
  );

  // Trim-erase window follows the write gate.
  ddic_trim u_trim (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_act  (~hs.write_gate_n),
    .busy    (trim_busy)
  );

  // Straps captured in the first cycle after reset release. [RULE_24]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      first_reg  <= 1'b1;
      straps_reg <= '0;
    end else begin
      first_reg <= 1'b0;
      if (first_reg) begin
        straps_reg <= straps_in;
      end
    end
  end

  assign selected    = sel_decode(straps_reg.address_strap, straps_reg.always_select_strap,
                                  hs.select_n); // [RULE_21]
  assign step_fall   = step_prev_reg & ~hs.step_n & ~trim_busy; // [RULE_22] [RULE_23]
  assign stepping    = (pos_reg == ddic_pkg::DDIC_POS_MOVE) || step_fall;
  assign protected_w = straps_reg.protect_invert_strap ? ~notch_covered : notch_covered; // [RULE_13] [RULE_14]
  assign ready_w     = sector_seen_reg & at_speed; // [RULE_20]

  // Step edge detector; it starts high like the idle line, so reset release makes no false step.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      step_prev_reg <= 1'b1;
    end else begin
      step_prev_reg <= hs.step_n;
    end
  end

  // Spindle motor qualification by strap. [RULE_01] [RULE_02] [RULE_03]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      spindle_run <= 1'b0;
    end else if (straps_reg.motor_and_strap) begin
      spindle_run <= ~hs.spindle_on_n & selected;
    end else if (straps_reg.motor_or_strap) begin
      spindle_run <= ~hs.spindle_on_n | selected;
    end else begin
      spindle_run <= ~hs.spindle_on_n;
    end
  end

  // Positioner: one track per pulse, then a settle hold. [RULE_04] [RULE_05] [RULE_06]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pos_reg     <= ddic_pkg::DDIC_POS_HOLD;
      track_pos   <= `DDIC_TRACK_ZERO;
      hold_reg    <= '0;
      step_pulse  <= 1'b0;
      step_inward <= 1'b0;
    end else begin
      step_pulse <= 1'b0;
      if (step_fall) begin
        step_pulse  <= 1'b1;
        step_inward <= ~hs.seek_direction_n;
        hold_reg    <= `DDIC_HOLD_CYC;
        pos_reg     <= ddic_pkg::DDIC_POS_MOVE;
        if (~hs.seek_direction_n) begin
          if (track_pos != `DDIC_TRACK_LAST) begin
            track_pos <= track_pos + `DDIC_TRACK_W'(1);
          end
        end else if (track_pos != `DDIC_TRACK_ZERO) begin
          track_pos <= track_pos - `DDIC_TRACK_W'(1);
        end
      end else begin
        case (pos_reg)
          ddic_pkg::DDIC_POS_MOVE: begin
            if (hold_reg == '0) begin
              pos_reg <= ddic_pkg::DDIC_POS_HOLD;
            end else begin
              hold_reg <= hold_reg - 4'h1;
            end
          end
          ddic_pkg::DDIC_POS_HOLD: pos_reg <= ddic_pkg::DDIC_POS_HOLD;
          ddic_pkg::DDIC_POS_IDLE: pos_reg <= ddic_pkg::DDIC_POS_HOLD;
          default: pos_reg <= ddic_pkg::DDIC_POS_HOLD;
        endcase
      end
    end
  end

  // Track zero reported only when held at zero. [RULE_11] [RULE_12]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      home_track_n <= 1'b1;
    end else begin
      home_track_n <= ~((track_pos == `DDIC_TRACK_ZERO) && (pos_reg == ddic_pkg::DDIC_POS_HOLD) && !step_fall);
    end
  end

  // Head choice; direction-based choice frozen while stepping. [RULE_07] [RULE_08] [RULE_15]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dir_head_reg <= 1'b1;
      upper_head   <= 1'b1;
    end else begin
      if (!stepping) begin
        dir_head_reg <= ~hs.seek_direction_n;
      end
      if (!dual_head) begin
        upper_head <= 1'b0;
      end else if (straps_reg.direction_head_strap) begin
        upper_head <= stepping ? dir_head_reg : ~hs.seek_direction_n;
      end else begin
        upper_head <= ~hs.head_choice_n;
      end
    end
  end

  // Write gating and read path. [RULE_09] [RULE_10] [RULE_22]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      write_enable     <= 1'b0;
      write_flux_n     <= 1'b1;
      read_bitstream_n <= 1'b1;
    end else begin
      write_enable     <= ~hs.write_gate_n & ~protected_w & ~stepping;
      write_flux_n     <= (~hs.write_gate_n & ~protected_w & ~stepping) ? hs.write_bitstream_n : 1'b1;
      read_bitstream_n <= trim_busy ? 1'b1 : media_read_n;
    end
  end

  // Write-protect output. [RULE_13] [RULE_14]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      protect_status_n <= 1'b1;
    end else begin
      protect_status_n <= ~protected_w;
    end
  end

  // Door-open latch cleared by deselection; set wins. [RULE_17]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      door_open_seen_reg <= 1'b0;
    end else if (!door_closed) begin
      door_open_seen_reg <= 1'b1;
    end else if (!selected) begin
      door_open_seen_reg <= 1'b0;
    end
  end

  // Diskette presence from a sector pulse, lost when door opens. [RULE_20]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sector_seen_reg <= 1'b0;
    end else if (sector_hole) begin
      sector_seen_reg <= 1'b1;
    end else if (!door_closed) begin
      sector_seen_reg <= 1'b0;
    end
  end

  // Door-closed and drive-status outputs. [RULE_16] [RULE_17] [RULE_18] [RULE_19]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      door_closed_n  <= 1'b1;
      drive_status_n <= 1'b1;
    end else if (straps_reg.door_latch_bypass_strap) begin
      door_closed_n  <= ~door_closed;
      drive_status_n <= ~(selected & door_closed & ready_w);
    end else begin
      door_closed_n  <= ~door_closed | door_open_seen_reg;
      drive_status_n <= ~(selected & ~door_open_seen_reg & door_closed & ready_w);
    end
  end

  // Checks. Steps are described by named sequences first.
  sequence s_step_inward;
    step_fall && !hs.seek_direction_n && track_pos != `DDIC_TRACK_LAST;
  endsequence
  sequence s_step_outward;
    step_fall && hs.seek_direction_n && track_pos != `DDIC_TRACK_ZERO;
  endsequence
  // A step that has run out its settle time with the head at the home track.
  sequence s_settle_at_home;
    pos_reg == ddic_pkg::DDIC_POS_MOVE ##1
      (pos_reg == ddic_pkg::DDIC_POS_HOLD && track_pos == `DDIC_TRACK_ZERO && !step_fall);
  endsequence

  // Motor qualification.
  a_motor_and_gate: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_02]
    straps_reg.motor_and_strap && !selected |=> !spindle_run)
    else $error("Spindle ran while not selected under and-strap.");
  a_motor_plain: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_01]
    !straps_reg.motor_and_strap && !straps_reg.motor_or_strap |=> spindle_run == !$past(hs.spindle_on_n))
    else $error("Spindle did not follow motor-on.");
  a_motor_or_gate: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_03]
    straps_reg.motor_or_strap && !straps_reg.motor_and_strap && selected |=> spindle_run)
    else $error("Spindle off while selected under or-strap.");
  // Positioner.
  a_step_in_one: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_04]
    s_step_inward |=> track_pos == $past(track_pos) + `DDIC_TRACK_W'(1))
    else $error("Inward step did not add one track.");
  a_step_out_one: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_05]
    s_step_outward |=> track_pos == $past(track_pos) - `DDIC_TRACK_W'(1))
    else $error("Outward step did not remove one track.");
  a_step_pulse_once: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_06]
    step_pulse |=> !step_pulse)
    else $error("Step pulse counted twice.");
  a_step_refused: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_22]
    trim_busy |=> !step_pulse)
    else $error("Step accepted during write or trim erase.");
  a_home_track_hold: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_11]
    !home_track_n |-> $past(track_pos) == `DDIC_TRACK_ZERO)
    else $error("Track zero shown away from track zero.");
  a_home_after_hold: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_11]
    s_settle_at_home |=> !home_track_n)
    else $error("Track zero missing after settling at home.");
  // Head choice.
  a_head_line: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_15]
    dual_head && !straps_reg.direction_head_strap |=> upper_head == !$past(hs.head_choice_n))
    else $error("Head did not follow the head-select line.");
  a_head_frozen: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_08]
    dual_head && straps_reg.direction_head_strap && stepping && $past(stepping) |=> $stable(upper_head))
    else $error("Direction head choice changed while stepping.");
  // Write and read paths.
  a_write_blocked: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_09]
    protected_w |=> !write_enable)
    else $error("Write enabled on protected diskette.");
  a_write_no_step: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_09]
    stepping |=> !write_enable)
    else $error("Write enabled while stepping.");
  a_read_blocked: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_22]
    trim_busy |=> read_bitstream_n)
    else $error("Read data passed during write or trim erase.");
  a_protect_normal: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_13]
    !straps_reg.protect_invert_strap |=> protect_status_n == !$past(notch_covered))
    else $error("Protect output wrong under normal polarity.");
  a_protect_invert: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_14]
    straps_reg.protect_invert_strap |=> protect_status_n == $past(notch_covered))
    else $error("Protect output wrong under inverted polarity.");
  // Door and status.
  a_door_follows: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_16]
    straps_reg.door_latch_bypass_strap |=> door_closed_n == !$past(door_closed))
    else $error("Door-closed did not follow the door under bypass.");
  a_door_latch_holds: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_17]
    !straps_reg.door_latch_bypass_strap && door_open_seen_reg && selected |=> door_closed_n)
    else $error("Door-closed dropped before deselect.");
  a_status_needs_ready: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_18]
    !drive_status_n |-> $past(ready_w) && $past(selected))
    else $error("Drive status asserted without ready and select.");
  a_status_not_ready: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_20]
    !ready_w |=> drive_status_n)
    else $error("Drive status asserted while not ready.");

endmodule

// [verif/ddic_host_model.sv]
/*
  Behavioural model of the host disk controller on the drive cable.
  Assumes the bench calls its tasks from a process clocked by sys_clk.
*/
`timescale 1ns/1ns
module ddic_host_model (
  input  wire logic               sys_clk,   // System clock.
  output ddic_pkg::ddic_host_in_t host_out,  // Active-low host lines.
  output logic [7:0]              track_est  // Track count kept by the host.
);
  // All lines idle high and the host believes the head sits at the home track.
  initial begin
    host_out  = '1;
    track_est = 8'h00;
  end

  // Sets the level lines just after a clock edge.
  task automatic drive(input logic [3:0] sel_n, input logic spin_n, input logic dir_n,
                       input logic gate_n, input logic head_n);
    @(posedge sys_clk);
    host_out.select_n         <= sel_n;
    host_out.spindle_on_n     <= spin_n;
    host_out.seek_direction_n <= dir_n;
    host_out.write_gate_n     <= gate_n;
    host_out.head_choice_n    <= head_n;
  endtask

  // Sets the write data line just after a clock edge.
  task automatic wdata(input logic bit_n);
    @(posedge sys_clk);
    host_out.write_bitstream_n <= bit_n;
  endtask

  // One step pulse: direction settles first and is held until the pulse is long gone.
  task automatic step_once(input logic dir_n);
    @(posedge sys_clk);
    host_out.seek_direction_n <= dir_n;
    @(posedge sys_clk);
    host_out.step_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    host_out.step_n <= 1'b1;
    // The host keeps its own running count, saturating like the positioner.
    if (!dir_n && track_est != 8'hff) track_est = track_est + 8'h01;
    else if (dir_n && track_est != 8'h00) track_est = track_est - 8'h01;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule

// [verif/tb_top.sv]
/*
  Self-checking bench of the drive interface control block.
  Assumes the package, the design files and the host model compile first.
*/
`timescale 1ns/1ns
module tb_top;
  logic                    sys_clk = 1'b0;
  logic                    srst    = 1'b1;
  ddic_pkg::ddic_straps_t  straps  = '0;
  ddic_pkg::ddic_host_in_t host_in;
  logic                    door    = 1'b1;
  logic                    notch   = 1'b0;
  logic                    sector  = 1'b0;
  logic                    speed   = 1'b1;
  logic                    dual    = 1'b1;
  logic                    media_n = 1'b1;
  logic                    spin, pulse, inward, upper, wr_en, flux_n, rd_n, home_n, prot_n, door_n, stat_n;
  logic [7:0]              track, track_est;
  int                      n_mismatch = 0;
  int                      compares   = 0;
  int                      n_pulse    = 0;

  // Free-running 50 MHz clock.
  always #10 sys_clk = ~sys_clk;

  // Counts the cycles in which a step reaches the stepper.
  always @(posedge sys_clk) if (pulse === 1'b1) n_pulse <= n_pulse + 1;

  ddic_top DUT (.sys_clk(sys_clk), .srst(srst), .straps_in(straps), .host_in(host_in), .door_closed(door),
    .notch_covered(notch), .sector_hole(sector), .at_speed(speed), .dual_head(dual), .media_read_n(media_n),
    .spindle_run(spin), .step_pulse(pulse), .step_inward(inward), .upper_head(upper), .write_enable(wr_en),
    .write_flux_n(flux_n), .read_bitstream_n(rd_n), .home_track_n(home_n), .protect_status_n(prot_n),
    .door_closed_n(door_n), .drive_status_n(stat_n), .track_pos(track));

  ddic_host_model u_host (.sys_clk(sys_clk), .host_out(host_in), .track_est(track_est));

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Lets host line changes pass the synchroniser and output registers.
  task automatic settle();
    repeat (5) @(posedge sys_clk);
    #1;
  endtask

  // Builds straps from {always-select, and, or, dir-head, sep-head, bypass, invert}; address line 1.
  function automatic ddic_pkg::ddic_straps_t mk(input logic [6:0] f);
    mk = '0;
    {mk.motor_and_strap, mk.motor_or_strap, mk.direction_head_strap, mk.separate_head_strap,
     mk.door_latch_bypass_strap, mk.protect_invert_strap} = f[5:0];
    mk.always_select_strap    = f[6];
    mk.protect_normal_strap_a = ~f[0];
    mk.protect_normal_strap_b = ~f[0];
    mk.address_strap          = 4'h1;
  endfunction

  // Resets for six cycles with the given straps and idle host lines, except the write data line, which keeps its last value.
  task automatic do_reset(input logic [6:0] f);
    @(posedge sys_clk);
    srst   <= 1'b1;
    straps <= mk(f);
    u_host.drive(4'hf, 1'b1, 1'b1, 1'b1, 1'b1);
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    settle();
  endtask

  // Motor follows motor-on alone, with select, or with either, by strap.
  task automatic t_motor();
    logic [6:0] f [4] = '{7'h00, 7'h20, 7'h10, 7'h60};
    logic       sel, mot, exp;
    for (int m = 0; m < 4; m++) begin
      do_reset(f[m]);
      for (int i = 0; i < 4; i++) begin
        sel = i[0];
        mot = i[1];
        u_host.drive(sel ? 4'he : 4'hd, ~mot, 1'b1, 1'b1, 1'b1);
        settle();
        exp = (m == 0 || m == 3) ? mot : (m == 1) ? (mot & sel) : (mot | sel);
        chk(spin, exp, "spindle");
      end
    end
  endtask

  // Inward and outward steps, one track each, and the home indication.
  task automatic t_step();
    do_reset(6'h00);
    chk(home_n, 1'b0, "home after reset");
    n_pulse = 0;
    repeat (3) u_host.step_once(1'b0);
    chk(track, u_host.track_est, "track inward");
    chk(inward, 1'b1, "direction inward");
    chk(8'(n_pulse), 8'h03, "pulse count");
    chk(home_n, 1'b1, "home off track");
    repeat (3) u_host.step_once(1'b1);
    repeat (12) @(posedge sys_clk);
    #1;
    chk(track, 8'h00, "track outward");
    chk(inward, 1'b0, "direction outward");
    chk(home_n, 1'b0, "home after hold");
    u_host.step_once(1'b1);
    settle();
    chk(track, 8'h00, "no step below home");
  endtask

  // Head picked by the dedicated line or by the direction line.
  task automatic t_head();
    do_reset(6'h04);
    u_host.drive(4'he, 1'b1, 1'b1, 1'b1, 1'b0);
    settle();
    chk(upper, 1'b1, "head line low");
    u_host.drive(4'he, 1'b1, 1'b1, 1'b1, 1'b1);
    settle();
    chk(upper, 1'b0, "head line high");
    do_reset(6'h08);
    u_host.drive(4'he, 1'b1, 1'b0, 1'b1, 1'b1);
    settle();
    chk(upper, 1'b1, "direction low head");
    u_host.drive(4'he, 1'b1, 1'b1, 1'b1, 1'b0);
    settle();
    chk(upper, 1'b0, "direction high head");
    u_host.step_once(1'b0);
    u_host.drive(4'he, 1'b1, 1'b1, 1'b1, 1'b1);
    repeat (3) @(posedge sys_clk);
    #1;
    chk(upper, 1'b1, "head frozen while stepping");
    settle();
    chk(upper, 1'b0, "head follows after settle");
  endtask

  // Door output and drive status, with and without the open latch.
  task automatic t_door();
    do_reset(6'h02);
    u_host.drive(4'he, 1'b1, 1'b1, 1'b1, 1'b1);
    settle();
    chk(stat_n, 1'b1, "no sector seen");
    sector <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sector <= 1'b0;
    settle();
    chk(stat_n, 1'b0, "status bypass");
    chk(door_n, 1'b0, "door closed");
    door <= 1'b0;
    settle();
    chk({door_n, stat_n}, 2'b11, "door open bypass");
    door <= 1'b1;
    settle();
    chk(door_n, 1'b0, "door shut bypass");
    do_reset(6'h00);
    u_host.drive(4'he, 1'b1, 1'b1, 1'b1, 1'b1);
    sector <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sector <= 1'b0;
    settle();
    chk(stat_n, 1'b0, "status latched mode");
    door <= 1'b0;
    repeat (4) @(posedge sys_clk);
    door <= 1'b1;
    settle();
    chk({door_n, stat_n}, 2'b11, "open event held");
    u_host.drive(4'hf, 1'b1, 1'b1, 1'b1, 1'b1);
    settle();
    chk(door_n, 1'b0, "released on deselect");
    chk(stat_n, 1'b1, "status deselected");
    u_host.drive(4'he, 1'b1, 1'b1, 1'b1, 1'b1);
    sector <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sector <= 1'b0;
    settle();
    chk(stat_n, 1'b0, "status reselected");
    speed <= 1'b0;
    settle();
    chk(stat_n, 1'b1, "not at speed");
    speed <= 1'b1;
  endtask

  // Protect polarity, write gating, blocked steps and the read path after trim.
  task automatic t_write();
    do_reset(6'h00);
    notch   <= 1'b1;
    media_n <= 1'b0;
    u_host.drive(4'he, 1'b1, 1'b1, 1'b0, 1'b1);
    settle();
    chk({prot_n, wr_en}, 2'b00, "covered normal");
    notch <= 1'b0;
    settle();
    chk({prot_n, wr_en}, 2'b11, "uncovered normal");
    chk(rd_n, 1'b1, "read off in write");
    u_host.wdata(1'b0);
    settle();
    chk(flux_n, 1'b0, "write data to head");
    u_host.step_once(1'b0);
    settle();
    chk(track, 8'h00, "step ignored in write");
    u_host.drive(4'he, 1'b1, 1'b1, 1'b1, 1'b1);
    settle();
    chk({wr_en, rd_n, flux_n}, 3'b011, "trim blocks read");
    repeat (47600) @(posedge sys_clk);
    #1;
    chk(rd_n, 1'b0, "read passes low");
    media_n <= 1'b1;
    settle();
    chk(rd_n, 1'b1, "read passes high");
    do_reset(6'h01);
    u_host.drive(4'he, 1'b1, 1'b1, 1'b0, 1'b1);
    settle();
    chk({prot_n, wr_en, flux_n}, 3'b001, "uncovered invert");
    notch <= 1'b1;
    settle();
    chk({prot_n, wr_en, flux_n}, 3'b110, "covered invert");
  endtask

  // Main sequence.
  initial begin
    t_motor();
    t_step();
    t_head();
    t_door();
    t_write();
    give_verdict();
  end

  // Watchdog: the sequence needs about 50000 cycles.
  initial begin
    repeat (70000) @(posedge sys_clk);
    n_mismatch++;
    give_verdict();
  end
endmodule
